// [uaf_flow.sv]
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`default_nettype none
module uaf_flow #(
  parameter int unsigned BAUD_DIV = uaf_pkg::BAUD_DIV
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire uaf_pkg::uaf_axi_req_t axi_req,
  output var  uaf_pkg::uaf_axi_rsp_t axi_rsp,
  input  wire uaf_pkg::uaf_rx_char_t rx_char,
  input  wire logic                  cts_n,
  input  wire logic                  dsr_n,
  input  wire logic                  ri_n,
  input  wire logic                  dcd_n,
  output logic                       rts_n,
  output logic                       txd,
  output logic                       modem_irq
);

  // ==========================================================================
  // Elaboration checks
  generate
    if (BAUD_DIV < 2 || BAUD_DIV > (1 << uaf_pkg::BAUD_W)) begin : g_bad_div
      $error("BAUD_DIV out of range");
    end
  endgenerate

  localparam logic [uaf_pkg::BAUD_W-1:0] BAUD_LAST = uaf_pkg::BAUD_W'(BAUD_DIV - 1);

  // ==========================================================================
  // Decoding helpers
  function automatic logic [5:0] reg_index(input logic [uaf_pkg::ADDR_W-1:0] addr);
    reg_index = addr[uaf_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic reg_mapped(input logic [uaf_pkg::ADDR_W-1:0] addr);
    reg_mapped = (reg_index(addr) <= uaf_pkg::IDX_LEVEL);
  endfunction

  // Deassert level for a trigger code
  function automatic logic [uaf_pkg::CNT_W-1:0] trig_high(input logic [1:0] code);
    unique case (code)
      uaf_pkg::TRIG_1:  trig_high = uaf_pkg::LVL_1;
      uaf_pkg::TRIG_4:  trig_high = uaf_pkg::LVL_4;
      uaf_pkg::TRIG_8:  trig_high = uaf_pkg::LVL_8;
      uaf_pkg::TRIG_14: trig_high = uaf_pkg::LVL_14;
    endcase
  endfunction

  // Reassert level: the next lower trigger, empty for the lowest
  function automatic logic [uaf_pkg::CNT_W-1:0] trig_low(input logic [1:0] code);
    unique case (code)
      uaf_pkg::TRIG_1:  trig_low = uaf_pkg::LVL_0;
      uaf_pkg::TRIG_4:  trig_low = uaf_pkg::LVL_1;
      uaf_pkg::TRIG_8:  trig_low = uaf_pkg::LVL_4;
      uaf_pkg::TRIG_14: trig_low = uaf_pkg::LVL_8;
    endcase
  endfunction

  uaf_pkg::uaf_state_t state_reg;
  uaf_pkg::uaf_state_t state_next;

  // ==========================================================================
  // Next state
  always_comb begin
    logic                         wr_take;
    logic                         rd_take;
    logic [5:0]                   wr_idx;
    logic [5:0]                   rd_idx;
    logic                         wr_lane;
    logic                         pop;
    logic                         push;
    logic                         full;
    logic [3:0]                   pins;
    logic                         lsr_read;
    logic                         msr_read;
    logic [31:0]                  rd_val;
    logic                         cts_ok;
    wr_take  = 1'b0;
    rd_take  = 1'b0;
    wr_idx   = 6'h00;
    rd_idx   = 6'h00;
    wr_lane  = 1'b0;
    pop      = 1'b0;
    push     = 1'b0;
    full     = 1'b0;
    pins     = 4'h0;
    lsr_read = 1'b0;
    msr_read = 1'b0;
    rd_val   = 32'h0000_0000;
    cts_ok   = 1'b0;
    state_next = state_reg;

    // ========================================================================
    // Bus slave: address and data taken together, one of each in flight
    wr_take = state_reg.wr_rdy && axi_req.awvalid && axi_req.wvalid;
    rd_take = state_reg.ar_rdy && axi_req.arvalid;
    wr_idx  = reg_index(axi_req.awaddr);
    rd_idx  = reg_index(axi_req.araddr);
    wr_lane = wr_take && axi_req.wstrb[0] && reg_mapped(axi_req.awaddr);

    state_next.wr_rdy = axi_req.awvalid && axi_req.wvalid && !state_reg.wr_rdy &&
                        !state_reg.bvalid;
    state_next.ar_rdy = axi_req.arvalid && !state_reg.ar_rdy && !state_reg.rvalid;

    if (state_reg.bvalid && axi_req.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_take) begin
      state_next.bvalid = 1'b1;
      state_next.bresp  = reg_mapped(axi_req.awaddr) ? uaf_pkg::RESP_OKAY
                                                     : uaf_pkg::RESP_SLVERR;
    end

    // Read data assembled from the current state
    unique case (rd_idx)
      uaf_pkg::IDX_DATA: begin
        rd_val[7:0] = state_reg.mem[state_reg.rd_ptr][7:0];
      end
      uaf_pkg::IDX_IER: begin
        rd_val[uaf_pkg::IER_MSI_BIT] = state_reg.ier_msi;
        rd_val[uaf_pkg::IER_CTS_BIT] = state_reg.ier_cts;
      end
      uaf_pkg::IDX_FCR: begin
        rd_val[uaf_pkg::FCR_EN_BIT] = state_reg.fifo_en;
        rd_val[uaf_pkg::FCR_TRIG_LSB +: 2] = state_reg.trig;
      end
      uaf_pkg::IDX_MCR: begin
        rd_val[uaf_pkg::MCR_RTS_BIT]  = state_reg.mcr_rts;
        rd_val[uaf_pkg::MCR_ARTS_BIT] = state_reg.auto_request_enable;
        rd_val[uaf_pkg::MCR_ACTS_BIT] = state_reg.auto_clear_enable;
      end
      uaf_pkg::IDX_LSR: begin
        rd_val[uaf_pkg::LSR_RDR_BIT]  = (state_reg.count != uaf_pkg::LVL_0);
        rd_val[uaf_pkg::LSR_OE_BIT]   = state_reg.overrun;
        rd_val[uaf_pkg::LSR_PE_BIT]   = state_reg.parity_fault_flag;
        rd_val[uaf_pkg::LSR_THRE_BIT] = !state_reg.thr_full;
        rd_val[uaf_pkg::LSR_TEMT_BIT] = !state_reg.thr_full &&
                                        (state_reg.tx_state == uaf_pkg::TX_IDLE);
      end
      uaf_pkg::IDX_MSR: begin
        rd_val[7:0] = {~state_reg.pin_s2[uaf_pkg::PIN_DCD], ~state_reg.pin_s2[uaf_pkg::PIN_RI],
                       ~state_reg.pin_s2[uaf_pkg::PIN_DSR], ~state_reg.pin_s2[uaf_pkg::PIN_CTS],
                       state_reg.d_dcd, state_reg.te_ri, state_reg.d_dsr, state_reg.d_cts};
      end
      uaf_pkg::IDX_LEVEL: begin
        rd_val[uaf_pkg::CNT_W-1:0] = state_reg.count;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase

    if (state_reg.rvalid && axi_req.rready) begin
      state_next.rvalid = 1'b0;
    end
    // Read data is captured at the take edge, so a late rready still sees it unchanged
    if (rd_take) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_val;
      state_next.rresp  = reg_mapped(axi_req.araddr) ? uaf_pkg::RESP_OKAY
                                                     : uaf_pkg::RESP_SLVERR;
      lsr_read = (rd_idx == uaf_pkg::IDX_LSR);
      msr_read = (rd_idx == uaf_pkg::IDX_MSR);
      pop      = (rd_idx == uaf_pkg::IDX_DATA) && (state_reg.count != uaf_pkg::LVL_0);
    end

    // ========================================================================
    // Control register writes
    if (wr_lane) begin
      unique case (wr_idx)
        uaf_pkg::IDX_DATA: begin
          state_next.thr_data = axi_req.wdata[7:0];
          state_next.thr_full = 1'b1;
        end
        uaf_pkg::IDX_IER: begin
          state_next.ier_msi = axi_req.wdata[uaf_pkg::IER_MSI_BIT];
          state_next.ier_cts = axi_req.wdata[uaf_pkg::IER_CTS_BIT];
        end
        uaf_pkg::IDX_FCR: begin
          state_next.fifo_en = axi_req.wdata[uaf_pkg::FCR_EN_BIT];
          state_next.trig    = axi_req.wdata[uaf_pkg::FCR_TRIG_LSB +: 2];
        end
        uaf_pkg::IDX_MCR: begin
          if (!state_reg.auto_request_enable) begin
            state_next.mcr_rts = axi_req.wdata[uaf_pkg::MCR_RTS_BIT];
          end
          state_next.auto_request_enable = axi_req.wdata[uaf_pkg::MCR_ARTS_BIT];
          state_next.auto_clear_enable   = axi_req.wdata[uaf_pkg::MCR_ACTS_BIT];
        end
        default: begin
          state_next.thr_full = state_reg.thr_full;
        end
      endcase
    end

    // ========================================================================
    // Receive FIFO; with the FIFO off it holds a single character
    full = state_reg.fifo_en ? (state_reg.count == uaf_pkg::LVL_FULL)
                             : (state_reg.count != uaf_pkg::LVL_0);
    push = rx_char.valid && !full;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = {rx_char.parity_bad, rx_char.data};
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
    // Changing the mode flushes stale entries so the capacity stays honest
    if (state_next.fifo_en != state_reg.fifo_en) begin
      state_next.wr_ptr = '0;
      state_next.rd_ptr = '0;
      state_next.count  = uaf_pkg::LVL_0;
    end

    // ========================================================================
    // Line status flags: a read clears, a set in the same cycle wins
    if (lsr_read) begin
      state_next.overrun           = 1'b0;
      state_next.parity_fault_flag = 1'b0;
    end
    // The new character is dropped; the FIFO keeps what it already holds
    if (rx_char.valid && full) begin
      state_next.overrun = 1'b1;
    end
    // Flag raised once per head entry, so later characters never taint it
    if (state_reg.count != uaf_pkg::LVL_0 && !state_reg.pe_seen &&
        state_reg.mem[state_reg.rd_ptr][8]) begin
      state_next.parity_fault_flag = 1'b1;
      state_next.pe_seen           = 1'b1;
    end
    if (pop || state_reg.count == uaf_pkg::LVL_0) begin
      state_next.pe_seen = 1'b0;
    end

    // ========================================================================
    // Automatic request-to-send with hysteresis, checked every cycle
    if (state_reg.auto_request_enable) begin
      if (state_reg.count >= trig_high(state_reg.trig)) begin
        state_next.rts_n = 1'b1;
      end else if (state_reg.count <= trig_low(state_reg.trig)) begin
        state_next.rts_n = 1'b0;
      end else begin
        state_next.rts_n = state_reg.rts_n;
      end
      // Mirror lags the pin by one cycle; software writes to the bit are lost
      state_next.mcr_rts = ~state_reg.rts_n;
    end else begin
      state_next.rts_n = ~state_reg.mcr_rts;
    end

    // ========================================================================
    // Modem inputs: two flops, then edge detection on the second
    // Flops reset to the idle pin level, so no false delta follows reset
    state_next.pin_s1   = {dcd_n, ri_n, dsr_n, cts_n};
    state_next.pin_s2   = state_reg.pin_s1;
    state_next.pin_prev = state_reg.pin_s2;
    pins = state_reg.pin_s2;
    if (msr_read) begin
      state_next.d_cts = 1'b0;
      state_next.d_dsr = 1'b0;
      state_next.te_ri = 1'b0;
      state_next.d_dcd = 1'b0;
    end
    if (pins[uaf_pkg::PIN_CTS] != state_reg.pin_prev[uaf_pkg::PIN_CTS]) begin
      state_next.d_cts = 1'b1;
    end
    if (pins[uaf_pkg::PIN_DSR] != state_reg.pin_prev[uaf_pkg::PIN_DSR]) begin
      state_next.d_dsr = 1'b1;
    end
    if (pins[uaf_pkg::PIN_RI] && !state_reg.pin_prev[uaf_pkg::PIN_RI]) begin
      state_next.te_ri = 1'b1;
    end
    if (pins[uaf_pkg::PIN_DCD] != state_reg.pin_prev[uaf_pkg::PIN_DCD]) begin
      state_next.d_dcd = 1'b1;
    end
    state_next.modem_irq = state_reg.ier_msi &&
                           ((state_reg.d_dcd || state_reg.te_ri || state_reg.d_dsr) ||
                            (state_reg.d_cts &&
                             (!state_reg.auto_clear_enable || state_reg.ier_cts)));

    // ========================================================================
    // Transmitter: clear-to-send checked only between characters
    cts_ok = !state_reg.auto_clear_enable || !pins[uaf_pkg::PIN_CTS];
    unique case (state_reg.tx_state)
      uaf_pkg::TX_IDLE: begin
        state_next.txd = 1'b1;
        if (state_reg.thr_full && cts_ok) begin
          state_next.tx_shift = {1'b1, state_reg.thr_data, 1'b0};
          state_next.tx_bits  = 4'(uaf_pkg::FRAME_BITS - 1);
          state_next.baud_cnt = BAUD_LAST;
          state_next.txd      = 1'b0;
          // A write landing in this very cycle refills the holding register: the set wins
          state_next.thr_full = wr_lane && (wr_idx == uaf_pkg::IDX_DATA);
          state_next.tx_state = uaf_pkg::TX_SEND;
        end
      end
      uaf_pkg::TX_SEND: begin
        if (state_reg.baud_cnt != '0) begin
          state_next.baud_cnt = state_reg.baud_cnt - 1'b1;
        end else if (state_reg.tx_bits == 4'h0) begin
          state_next.tx_state = uaf_pkg::TX_IDLE;
          state_next.txd      = 1'b1;
        end else begin
          state_next.tx_shift = {1'b1, state_reg.tx_shift[uaf_pkg::FRAME_BITS-1:1]};
          state_next.txd      = state_reg.tx_shift[1];
          state_next.tx_bits  = state_reg.tx_bits - 1'b1;
          state_next.baud_cnt = BAUD_LAST;
        end
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.rts_n    <= uaf_pkg::RTS_N_RESET;
      state_reg.txd      <= uaf_pkg::TXD_RESET;
      state_reg.pin_s1   <= uaf_pkg::PIN_RESET;
      state_reg.pin_s2   <= uaf_pkg::PIN_RESET;
      state_reg.pin_prev <= uaf_pkg::PIN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  always_comb begin
    axi_rsp.awready = state_reg.wr_rdy;
    axi_rsp.wready  = state_reg.wr_rdy;
    axi_rsp.bvalid  = state_reg.bvalid;
    axi_rsp.bresp   = state_reg.bresp;
    axi_rsp.arready = state_reg.ar_rdy;
    axi_rsp.rvalid  = state_reg.rvalid;
    axi_rsp.rdata   = state_reg.rdata;
    axi_rsp.rresp   = state_reg.rresp;
    rts_n           = state_reg.rts_n;
    txd             = state_reg.txd;
    modem_irq       = state_reg.modem_irq;
  end

endmodule
`default_nettype wire

// [uaf_flow_bench.sv]
`default_nettype none
module uaf_flow_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
    logic       rts;
  } uaf_row_t;
  localparam uaf_row_t ROWS [6] = '{'{8'h04, 8'h88, 8'h88, 2'h0, 1'b1},
    '{8'h08, 8'h81, 8'h81, 2'h0, 1'b1}, '{8'h0c, 8'h02, 8'h02, 2'h0, 1'b0},
    '{8'h0c, 8'h00, 8'h00, 2'h0, 1'b1}, '{8'h10, 8'hff, 8'h60, 2'h0, 1'b1},
    '{8'h1c, 8'hff, 8'h00, 2'h2, 1'b1}};
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  stop = 1'b1;
  logic                  dsr_n = 1'b1;
  logic                  ri_n = 1'b1;
  logic                  cts_n, rts_n, txd, irq;
  logic [7:0]            got;
  logic [31:0]           rd_d;
  logic [1:0]            rd_r;
  int                    got_cnt, error_cnt = 0, n_tests = 0;
  uaf_pkg::uaf_axi_req_t req = '0;
  uaf_pkg::uaf_axi_rsp_t rsp;
  uaf_pkg::uaf_rx_char_t rxc;
  always #25 sys_clk = ~sys_clk;
  uaf_flow #(.BAUD_DIV(4)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .axi_req(req),
    .axi_rsp(rsp), .rx_char(rxc), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(1'b1),
    .rts_n(rts_n), .txd(txd), .modem_irq(irq));
  uaf_remote #(.BAUD_DIV(4)) i_far (.sys_clk(sys_clk), .txd(txd), .stop(stop),
    .cts_n(cts_n), .rx_char(rxc), .got(got), .got_cnt(got_cnt));
  // ==========================================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do @(posedge sys_clk); while (!rsp.awready);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge sys_clk); while (!rsp.bvalid);
    // Ready comes late so the slave must hold its response a cycle
    req.bready <= 1'b1;
    @(posedge sys_clk);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge sys_clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge sys_clk);
    req.rready <= 1'b0;
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run is a few hundred cycles; twenty thousand means a hang
  initial begin
    #1_000_000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (ROWS[k]) begin
      wr(ROWS[k].a, {24'h0, ROWS[k].d});
      rd(ROWS[k].a);
      check("rdata", rd_d, {24'h0, ROWS[k].q});
      check("rresp", rd_r, ROWS[k].r);
      check("rts_n", rts_n, ROWS[k].rts);
    end
    wr(8'h0c, 32'h40);
    for (int i = 0; i < 8; i++) begin
      i_far.push(8'h10 + i, i == 0);
      repeat (2) @(posedge sys_clk);
      check("rts_n", rts_n, i == 7);
    end
    wr(8'h0c, 32'h42);
    rd(8'h0c);
    check("mcr", rd_d, 32'h40);
    rd(8'h10);
    check("lsr", rd_d, 32'h65);
    rd(8'h10);
    check("lsr", rd_d, 32'h61);
    for (int i = 0; i < 4; i++) begin
      rd(8'h00);
      check("head", rd_d, 32'h10 + i);
      repeat (2) @(posedge sys_clk);
      check("rts_n", rts_n, i != 3);
    end
    for (int i = 0; i < 13; i++) i_far.push(8'h20 + i, 1'b0);
    rd(8'h18);
    check("count", rd_d, 32'h10);
    rd(8'h10);
    check("lsr", rd_d, 32'h63);
    rd(8'h10);
    check("lsr", rd_d, 32'h61);
    rd(8'h00);
    check("head", rd_d, 32'h14);
    wr(8'h04, 32'h08);
    wr(8'h0c, 32'h80);
    wr(8'h00, 32'h55);
    repeat (60) @(posedge sys_clk);
    check("sent", got_cnt, 0);
    check("txd", txd, 1'b1);
    stop <= 1'b0;
    repeat (60) @(posedge sys_clk);
    check("byte", got, 8'h55);
    check("irq", irq, 1'b0);
    rd(8'h14);
    check("msr", rd_d, 32'h11);
    stop <= 1'b1;
    wr(8'h0c, 32'h00);
    wr(8'h00, 32'ha3);
    repeat (60) @(posedge sys_clk);
    check("byte", got, 8'ha3);
    check("irq", irq, 1'b1);
    rd(8'h14);
    repeat (2) @(posedge sys_clk);
    check("irq", irq, 1'b0);
    dsr_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("irq", irq, 1'b1);
    rd(8'h14);
    check("msr", rd_d, 32'h22);
    ri_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("irq", irq, 1'b0);
    ri_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("irq", irq, 1'b1);
    // Reset in mid-run must drop the interrupt and the auto request mode
    wr(8'h0c, 32'h40);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("irq", irq, 1'b0);
    reset_n <= 1'b1;
    rd(8'h0c);
    check("mcr", rd_d, 32'h0);
    rd(8'h18);
    check("count", rd_d, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire

// [uaf_monitor.sv]
`default_nettype none
module uaf_monitor #(
  parameter int unsigned BAUD_DIV = 4
) (
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  input wire uaf_pkg::uaf_axi_req_t axi_req,
  input wire uaf_pkg::uaf_axi_rsp_t axi_rsp,
  input wire logic                  rts_n,
  input wire logic                  txd,
  input wire logic                  modem_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Low run on the line: zero bits come in whole baud periods only
  logic [15:0] low_cnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) low_cnt <= 16'h0000;
    else low_cnt <= txd ? 16'h0000 : low_cnt + 16'h0001;
  end
  a_idle_lines: assert property ($rose(reset_n) |-> rts_n && txd && !modem_irq)
    else $error("lines not idle after reset");
  a_start_width: assert property ($rose(txd) |-> low_cnt != 0 && low_cnt % BAUD_DIV == 0)
    else $error("low run not whole baud periods");
  a_wr_answer: assert property ($rose(axi_rsp.awready) |-> axi_rsp.wready ##1 axi_rsp.bvalid)
    else $error("write response late");
  a_rd_answer: assert property (axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read response late");
  a_rd_hold: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped");
  a_bad_addr: assert property (axi_rsp.arready && axi_req.araddr > 8'h1b
    |=> axi_rsp.rresp == uaf_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_aw_w_pair: assert property (axi_rsp.awready |-> axi_rsp.wready ##1 !axi_rsp.awready)
    else $error("write channels split");
  cover property ($fell(rts_n));
  cover property ($rose(modem_irq));
  cover property ($fell(txd));
endmodule
bind uaf_flow uaf_monitor #(.BAUD_DIV(BAUD_DIV)) i_mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .rts_n(rts_n), .txd(txd), .modem_irq(modem_irq));
`default_nettype wire

// [uaf_pkg.sv]
`default_nettype none
package uaf_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned BAUD_HZ   = 115_200;
  localparam int unsigned BAUD_DIV  = CLK_HZ / BAUD_HZ;
  localparam int unsigned BAUD_W    = 16;
  localparam int unsigned FRAME_BITS = 10;

  // ==========================================================================
  // Register map, word indices (byte address bits 7:2)
  localparam int unsigned ADDR_W    = 8;
  localparam logic [5:0]  IDX_DATA  = 6'h00;
  localparam logic [5:0]  IDX_IER   = 6'h01;
  localparam logic [5:0]  IDX_FCR   = 6'h02;
  localparam logic [5:0]  IDX_MCR   = 6'h03;
  localparam logic [5:0]  IDX_LSR   = 6'h04;
  localparam logic [5:0]  IDX_MSR   = 6'h05;
  localparam logic [5:0]  IDX_LEVEL = 6'h06;

  // ==========================================================================
  // Field positions
  localparam int unsigned IER_MSI_BIT   = 3;
  localparam int unsigned IER_CTS_BIT   = 7;
  localparam int unsigned FCR_EN_BIT    = 0;
  localparam int unsigned FCR_TRIG_LSB  = 6;
  localparam int unsigned MCR_RTS_BIT   = 1;
  localparam int unsigned MCR_ARTS_BIT  = 6;
  localparam int unsigned MCR_ACTS_BIT  = 7;
  localparam int unsigned LSR_RDR_BIT   = 0;
  localparam int unsigned LSR_OE_BIT    = 1;
  localparam int unsigned LSR_PE_BIT    = 2;
  localparam int unsigned LSR_THRE_BIT  = 5;
  localparam int unsigned LSR_TEMT_BIT  = 6;

  // Modem pin bit order in the synchronisers
  localparam int unsigned PIN_CTS = 0;
  localparam int unsigned PIN_DSR = 1;
  localparam int unsigned PIN_RI  = 2;
  localparam int unsigned PIN_DCD = 3;

  // ==========================================================================
  // Receive FIFO and trigger levels
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam logic [1:0]  TRIG_1     = 2'h0;
  localparam logic [1:0]  TRIG_4     = 2'h1;
  localparam logic [1:0]  TRIG_8     = 2'h2;
  localparam logic [1:0]  TRIG_14    = 2'h3;
  localparam logic [CNT_W-1:0] LVL_0  = 5'h00;
  localparam logic [CNT_W-1:0] LVL_1  = 5'h01;
  localparam logic [CNT_W-1:0] LVL_4  = 5'h04;
  localparam logic [CNT_W-1:0] LVL_8  = 5'h08;
  localparam logic [CNT_W-1:0] LVL_14 = 5'h0e;
  localparam logic [CNT_W-1:0] LVL_FULL = 5'h10;

  // ==========================================================================
  // Reset values
  localparam logic RTS_N_RESET = 1'b1;
  localparam logic TXD_RESET   = 1'b1;
  localparam logic [3:0] PIN_RESET = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } uaf_tx_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } uaf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } uaf_axi_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_bad;
  } uaf_rx_char_t;

  typedef struct packed {
    logic                        wr_rdy;
    logic                        ar_rdy;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic                        ier_msi;
    logic                        ier_cts;
    logic                        fifo_en;
    logic [1:0]                  trig;
    logic                        mcr_rts;
    logic                        auto_request_enable;
    logic                        auto_clear_enable;
    logic                        rts_n;
    logic [FIFO_DEPTH-1:0][8:0]  mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        overrun;
    logic                        parity_fault_flag;
    logic                        pe_seen;
    logic [3:0]                  pin_s1;
    logic [3:0]                  pin_s2;
    logic [3:0]                  pin_prev;
    logic                        d_cts;
    logic                        d_dsr;
    logic                        te_ri;
    logic                        d_dcd;
    logic                        modem_irq;
    logic [7:0]                  thr_data;
    logic                        thr_full;
    uaf_tx_state_t               tx_state;
    logic [FRAME_BITS-1:0]       tx_shift;
    logic [3:0]                  tx_bits;
    logic [BAUD_W-1:0]           baud_cnt;
    logic                        txd;
  } uaf_state_t;

endpackage
`default_nettype wire

// [uaf_remote.sv]
`default_nettype none
module uaf_remote #(
  parameter int unsigned BAUD_DIV = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             txd,
  input  wire logic             stop,
  output logic                  cts_n,
  output uaf_pkg::uaf_rx_char_t rx_char,
  output logic [7:0]            got,
  output int                    got_cnt
);
  // ==========================================================================
  // Stop only changes between frames, well before any mid stop bit
  assign cts_n = stop;
  initial begin
    rx_char = '0;
    got = 8'h00;
    got_cnt = 0;
    forever begin
      @(negedge txd);
      repeat (BAUD_DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge sys_clk);
        got[i] = txd;
      end
      repeat (BAUD_DIV) @(posedge sys_clk);
      got_cnt++;
    end
  end
  // Released data shows its inverse so a stale value never looks valid
  task automatic push(input logic [7:0] d, input logic pb);
    @(posedge sys_clk);
    rx_char <= '{1'b1, d, pb};
    @(posedge sys_clk);
    rx_char <= '{1'b0, ~d, ~pb};
  endtask
endmodule
`default_nettype wire
